// ---- rtl/ccc_pkg.sv ----
package ccc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // configuration word of one card, kept per card
    typedef struct packed {
        logic unused_bit7;
        logic unused_bit6;
        logic stop_level_select;
        logic clock_stop_request;
        logic sync_card_clock_bit;
        logic [2:0] freq_select_field;
    } ccc_cfg_s;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; the byte address is four times the index
    localparam logic [7:0] CCC_IDX_CSEL = 8'h00;
    localparam logic [7:0] CCC_IDX_CFG = 8'h01;
    localparam logic [7:0] CCC_IDX_MSR = 8'h0C;
    localparam logic [7:0] CCC_IDX_DATA = 8'h0D;
    localparam logic [7:0] CCC_IDX_ISTAT = 8'h10;
    localparam logic [7:0] CCC_IDX_IMASK = 8'h11;
    localparam logic [7:0] CCC_ADDR_CSEL = {CCC_IDX_CSEL[5:0], 2'b00};
    localparam logic [7:0] CCC_ADDR_CFG = {CCC_IDX_CFG[5:0], 2'b00};
    localparam logic [7:0] CCC_ADDR_MSR = {CCC_IDX_MSR[5:0], 2'b00};
    localparam logic [7:0] CCC_ADDR_DATA = {CCC_IDX_DATA[5:0], 2'b00};
    localparam logic [7:0] CCC_ADDR_ISTAT = {CCC_IDX_ISTAT[5:0], 2'b00};
    localparam logic [7:0] CCC_ADDR_IMASK = {CCC_IDX_IMASK[5:0], 2'b00};

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CCC_CSEL_SYNC_BIT = 4;
    localparam int CCC_CSEL_DBL_BIT = 5;
    localparam int CCC_MSR_SWITCH_BIT = 7;
    localparam int CCC_IRQ_SWITCH = 0;
    localparam int CCC_IRQ_STOP = 1;
    localparam int CCC_NUM_IRQ = 2;
    localparam int CCC_NUM_CARDS = 3;
    localparam int CCC_NUM_CLK_CARDS = 2;
    localparam logic [1:0] CCC_CARD_NONE = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam ccc_cfg_s CCC_CFG_RESET = 8'h00;
    localparam logic [1:0] CCC_CSEL_RESET = 2'h0;
    localparam logic [CCC_NUM_IRQ-1:0] CCC_IRQ_RESET = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // half periods of the card clock in pclk cycles; the crystal rate is pclk/2
    localparam logic [3:0] CCC_XTAL_HALF = 4'h1;
    localparam logic [3:0] CCC_INT_HALF = 4'h3;

    function automatic logic [3:0] ccc_half_cycles(input logic [2:0] sel);
        // top bit alone picks the oscillator source
        if (sel[2]) begin
            return CCC_INT_HALF;
        end
        return CCC_XTAL_HALF << sel[1:0];
    endfunction

endpackage

// ---- rtl/ccc_half_div.sv ----
module ccc_half_div import ccc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic restart,
    input wire logic [2:0] sel,
    output logic tick
);

    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [3:0] half;

    ////////////////////////////////////////////////////////////////////////////
    // >= so a switch to a faster rate can never skip the wrap
    always_comb begin
        half = ccc_half_cycles(sel);
        tick = !restart && (cnt_reg >= 4'(half - 4'h1));
        cnt_next = cnt_reg + 4'h1;
        if (restart || tick) begin
            cnt_next = 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule

// ---- rtl/ccc_card_clock.sv ----
// Function
// - stop holds clock at stop-level value
// - stop bit chooses stopped or selected frequency
// - sync card: clock copies sync bit
// - sync receive: io level in bit 0
// - sync transmit: written bit held until reselect
// - frequency changes glitch-free, no runt pulses
// - codes 000-011 crystal divide, 1xx oscillator half
// - source switch delayed; software polls switch flag
// - switch flag is status bit 7
// - cards 1-2 clock, uart clock doubling
module ccc_card_clock import ccc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic io_in,
    output logic io_out,
    output logic io_oe,
    output logic [CCC_NUM_CLK_CARDS-1:0] card_clk,
    output logic uart_tick,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    ccc_cfg_s cfg_mem [CCC_NUM_CARDS];
    ccc_cfg_s cfg_next [CCC_NUM_CARDS];
    ccc_cfg_s cfg;
    logic [1:0] sel_reg, sel_next;
    logic sync_mode_reg, sync_mode_next;
    logic uart_dbl_reg, uart_dbl_next;
    logic [CCC_NUM_IRQ-1:0] mask_reg, mask_next;
    logic [CCC_NUM_IRQ-1:0] stat_reg, stat_next;
    logic [CCC_NUM_IRQ-1:0] events;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic irq_reg, irq_next;
    logic io_out_reg, io_out_next;
    logic io_oe_reg, io_oe_next;
    logic [2:0] act_sel_reg, act_sel_next;
    logic clk_int_reg, clk_int_next;
    logic [CCC_NUM_CLK_CARDS-1:0] card_clk_reg, card_clk_next;
    logic uart_tick_reg, uart_tick_next;
    logic io_s1_reg, io_s2_reg, io_s3_reg, io_filt_reg;
    logic tick, toggle, pending;
    logic setup, acc, wr, rd;
    logic hit_csel, hit_cfg, hit_msr, hit_data, hit_istat, hit_imask;

    assign cfg = cfg_mem[sel_reg];

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, pready registered from the setup cycle
    assign setup = psel && !penable;
    assign acc = psel && penable && pready_reg;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign hit_csel = (paddr == CCC_ADDR_CSEL);
    assign hit_cfg = (paddr == CCC_ADDR_CFG);
    assign hit_msr = (paddr == CCC_ADDR_MSR);
    assign hit_data = (paddr == CCC_ADDR_DATA);
    assign hit_istat = (paddr == CCC_ADDR_ISTAT);
    assign hit_imask = (paddr == CCC_ADDR_IMASK);

    always_comb begin
        sel_next = sel_reg;
        sync_mode_next = sync_mode_reg;
        uart_dbl_next = uart_dbl_reg;
        mask_next = mask_reg;
        for (int k = 0; k < CCC_NUM_CARDS; k++) begin
            cfg_next[k] = cfg_mem[k];
        end
        if (wr && hit_csel) begin
            // code 3 names no card and is dropped
            if (pwdata[1:0] != CCC_CARD_NONE) begin
                sel_next = pwdata[1:0];
            end
            sync_mode_next = pwdata[CCC_CSEL_SYNC_BIT];
            uart_dbl_next = pwdata[CCC_CSEL_DBL_BIT];
        end
        if (wr && hit_cfg) begin
            cfg_next[sel_reg] = ccc_cfg_s'(pwdata[7:0]);
        end
        if (wr && hit_imask) begin
            mask_next = pwdata[CCC_NUM_IRQ-1:0];
        end
    end

    always_comb begin
        prdata_next = 32'h0000_0000;
        pslverr_next = 1'b0;
        pready_next = setup;
        if (setup && !pwrite) begin
            unique case (1'b1)
                hit_csel: begin
                    prdata_next[1:0] = sel_reg;
                    prdata_next[CCC_CSEL_SYNC_BIT] = sync_mode_reg;
                    prdata_next[CCC_CSEL_DBL_BIT] = uart_dbl_reg;
                end
                hit_cfg: prdata_next[7:0] = cfg;
                hit_msr: prdata_next[CCC_MSR_SWITCH_BIT] = pending;
                hit_data: prdata_next[0] = io_filt_reg;
                hit_istat: prdata_next[CCC_NUM_IRQ-1:0] = stat_reg;
                hit_imask: prdata_next[CCC_NUM_IRQ-1:0] = mask_reg;
                default: pslverr_next = 1'b1;
            endcase
        end else if (setup) begin
            pslverr_next = !(hit_csel || hit_cfg || hit_msr || hit_data || hit_imask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg <= CCC_CSEL_RESET;
            sync_mode_reg <= 1'b0;
            uart_dbl_reg <= 1'b0;
            mask_reg <= CCC_IRQ_RESET;
            for (int k = 0; k < CCC_NUM_CARDS; k++) begin
                cfg_mem[k] <= CCC_CFG_RESET;
            end
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            sel_reg <= sel_next;
            sync_mode_reg <= sync_mode_next;
            uart_dbl_reg <= uart_dbl_next;
            mask_reg <= mask_next;
            for (int k = 0; k < CCC_NUM_CARDS; k++) begin
                cfg_mem[k] <= cfg_next[k];
            end
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // card clock: outside sync mode the new select is taken only at a falling edge, so the
    // finished high phase is whole and the low phase runs at the new rate
    ccc_half_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .restart(sync_mode_reg),
        .sel(act_sel_reg),
        .tick(tick)
    );

    // only the source bit counts; a divide change alone is not reported
    assign pending = (act_sel_reg[2] != cfg.freq_select_field[2]);

    always_comb begin
        clk_int_next = clk_int_reg;
        act_sel_next = act_sel_reg;
        if (sync_mode_reg) begin
            clk_int_next = cfg.sync_card_clock_bit;
            act_sel_next = cfg.freq_select_field;
        end else if (tick) begin
            // bits 7 and 6 are stored but never looked at
            if (cfg.clock_stop_request && clk_int_reg == cfg.stop_level_select) begin
                clk_int_next = clk_int_reg;
            end else begin
                clk_int_next = !clk_int_reg;
                if (clk_int_reg) begin
                    act_sel_next = cfg.freq_select_field;
                end
            end
        end
    end

    assign toggle = (clk_int_next != clk_int_reg);

    always_comb begin
        uart_tick_next = toggle && (!clk_int_reg || uart_dbl_reg);
        events = '0;
        events[CCC_IRQ_SWITCH] = !sync_mode_reg && pending
            && (act_sel_next[2] == cfg.freq_select_field[2]);
        events[CCC_IRQ_STOP] = !sync_mode_reg && cfg.clock_stop_request && toggle
            && (clk_int_next == cfg.stop_level_select);
        stat_next = stat_reg;
        // clear only what the read returned; a new event always wins
        if (rd && hit_istat) begin
            stat_next = stat_reg & ~prdata_reg[CCC_NUM_IRQ-1:0];
        end
        stat_next = stat_next | events;
        irq_next = |(stat_next & mask_reg);
    end

    generate
        for (genvar i = 0; i < CCC_NUM_CLK_CARDS; i++) begin : g_card
            // unselected cards and card 3 see a quiet low clock
            always_comb begin
                card_clk_next[i] = (sel_reg == 2'(i)) ? clk_int_reg : 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // io line: the written level stays until another card is picked
    always_comb begin
        io_out_next = io_out_reg;
        io_oe_next = io_oe_reg;
        if (wr && hit_data && sync_mode_reg) begin
            io_out_next = pwdata[0];
            io_oe_next = 1'b1;
        end else if (wr && hit_csel && pwdata[1:0] != CCC_CARD_NONE
                && pwdata[1:0] != sel_reg) begin
            io_oe_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_sel_reg <= 3'h0;
            clk_int_reg <= 1'b0;
            card_clk_reg <= '0;
            uart_tick_reg <= 1'b0;
            stat_reg <= CCC_IRQ_RESET;
            irq_reg <= 1'b0;
            io_out_reg <= 1'b0;
            io_oe_reg <= 1'b0;
            io_s1_reg <= 1'b0;
            io_s2_reg <= 1'b0;
            io_s3_reg <= 1'b0;
            io_filt_reg <= 1'b0;
        end else begin
            act_sel_reg <= act_sel_next;
            clk_int_reg <= clk_int_next;
            card_clk_reg <= card_clk_next;
            uart_tick_reg <= uart_tick_next;
            stat_reg <= stat_next;
            irq_reg <= irq_next;
            io_out_reg <= io_out_next;
            io_oe_reg <= io_oe_next;
            io_s1_reg <= io_in;
            io_s2_reg <= io_s1_reg;
            io_s3_reg <= io_s2_reg;
            if (io_s2_reg == io_s3_reg) begin
                io_filt_reg <= io_s3_reg;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign io_out = io_out_reg;
    assign io_oe = io_oe_reg;
    assign card_clk = card_clk_reg;
    assign uart_tick = uart_tick_reg;
    assign irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks: cycles since the last tick or divider restart
    logic [3:0] gap_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_reg <= 4'h1;
        end else if (tick || sync_mode_reg) begin
            gap_reg <= 4'h1;
        end else if (gap_reg != 4'hF) begin
            gap_reg <= gap_reg + 4'h1;
        end
    end

    a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!sync_mode_reg && cfg.clock_stop_request && clk_int_reg == cfg.stop_level_select
         && $stable(cfg) && !(wr && (hit_cfg || hit_csel)))
        |=> clk_int_reg == $past(cfg.stop_level_select))
        else $error("stopped clock left its stop level");

    a_run_toggle: assert property (@(posedge pclk) disable iff (!presetn)
        (!sync_mode_reg && tick && !cfg.clock_stop_request) |=> $changed(clk_int_reg))
        else $error("running clock missed an edge");

    a_sync_copy: assert property (@(posedge pclk) disable iff (!presetn)
        (sync_mode_reg && $stable(sync_mode_reg)) |-> ##2
        card_clk[sel_reg[0]] == $past(cfg.sync_card_clock_bit, 2) || sel_reg[1])
        else $error("sync card clock does not follow its bit");

    a_rx_bit: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && hit_data) |=> prdata[0] == $past(io_filt_reg))
        else $error("receive bit 0 not the io level");

    a_tx_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_data && sync_mode_reg) |=> (io_oe && io_out == $past(pwdata[0]))
        ##1 (io_oe || $past(wr && hit_csel)))
        else $error("transmit level not driven and held");

    a_no_runt: assert property (@(posedge pclk) disable iff (!presetn)
        (!sync_mode_reg && tick && toggle) |-> gap_reg >= ccc_half_cycles(act_sel_reg))
        else $error("runt phase on card clock");

    a_sel_at_fall: assert property (@(posedge pclk) disable iff (!presetn)
        (!sync_mode_reg && act_sel_reg != act_sel_next) |-> (clk_int_reg && tick))
        else $error("select changed outside a falling edge");

    a_freq_exact: assert property (@(posedge pclk) disable iff (!presetn)
        (!sync_mode_reg && tick) |-> gap_reg == ccc_half_cycles(act_sel_reg))
        else $error("half period does not match select");

    a_osc_codes: assert property (@(posedge pclk) disable iff (!presetn)
        (!sync_mode_reg && tick && act_sel_reg[2]) |-> gap_reg == CCC_INT_HALF)
        else $error("oscillator code gave a crystal rate");

    a_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && hit_msr) |=> prdata[CCC_MSR_SWITCH_BIT] == $past(pending))
        else $error("switch flag not in status bit 7");

    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (!sync_mode_reg && pending && act_sel_next[2] == cfg.freq_select_field[2]
         && !(wr && (hit_cfg || hit_csel)))
        |=> !pending && stat_reg[CCC_IRQ_SWITCH])
        else $error("switch flag not cleared with the new rate");

    a_uart_double: assert property (@(posedge pclk) disable iff (!presetn)
        uart_tick == ($changed(clk_int_reg) && (clk_int_reg || $past(uart_dbl_reg))))
        else $error("uart clock edge missing");

endmodule

// ---- sim/ccc_card_model.sv ----
module ccc_card_model import ccc_pkg::*; (
    input wire logic pclk,
    input wire logic card_clk,
    input wire logic io_out,
    input wire logic io_oe,
    input wire logic card_drive,
    input wire logic card_level,
    input wire logic clr_min,
    output logic io_in,
    output logic [7:0] half_len,
    output logic [7:0] min_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev;
    logic [7:0] run;
    ////////////////////////////////////////////////////////////
    // io has a pull-up, so a released line reads high, never the last level
    assign io_in = io_oe ? io_out : (card_drive ? card_level : 1'b1);
    initial begin
        prev = 1'b0;
        run = 8'h00;
        half_len = 8'h00;
        min_len = 8'hFF;
    end
    ////////////////////////////////////////////////////////////
    // length of each level in pclk cycles; the shortest one exposes runt pulses
    always @(posedge pclk) begin
        prev <= card_clk;
        if (card_clk !== prev) begin
            half_len <= run;
            run <= 8'h01;
            if (!clr_min && run < min_len) begin
                min_len <= run;
            end
        end else if (run != 8'hFF) begin
            run <= run + 8'h01;
        end
        if (clr_min) begin
            min_len <= 8'hFF;
        end
    end
endmodule

// ---- sim/tb.sv ----
module tb import ccc_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic io_in, io_out, io_oe, uart_tick, irq, card_drive, card_level, clr_min;
    logic [7:0] paddr, half_len, min_len;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] card_clk;
    int num_errors, total_checks;

    ccc_card_clock dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .card_clk(card_clk), .uart_tick(uart_tick), .irq(irq));
    ccc_card_model card (.pclk(pclk), .card_clk(card_clk[0]), .io_out(io_out),
        .io_oe(io_oe), .card_drive(card_drive), .card_level(card_level),
        .clr_min(clr_min), .io_in(io_in), .half_len(half_len), .min_len(min_len));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            num_errors++;
            end_sim;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdr(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic clear_min;
        clr_min <= 1'b1;
        @(posedge pclk);
        clr_min <= 1'b0;
    endtask
    // bounded wait until card 1's clock has just taken level v
    task automatic clk_edge(input logic v);
        int n;
        n = 0;
        while (card_clk[0] === v && n < 40) begin
            @(posedge pclk);
            n++;
        end
        while (card_clk[0] !== v && n < 40) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 40) begin
            num_errors++;
            end_sim;
        end
    endtask
    // polls the pending flag the way software must before talking to the card
    task automatic wait_switch;
        int n;
        n = 0;
        do begin
            rdr(CCC_ADDR_MSR);
            n++;
        end while (rd[CCC_MSR_SWITCH_BIT] !== 1'b0 && n < 30);
        check(n < 30, 1'b1);
        if (n >= 30) begin
            end_sim;
        end
    endtask
    task automatic held(input logic v);
        logic ok;
        ok = 1'b1;
        cycles(20);
        repeat (16) begin
            @(posedge pclk);
            if (card_clk[0] !== v) ok = 1'b0;
        end
        check(ok, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdr(CCC_ADDR_CFG);
        check(rd, {24'h0, CCC_CFG_RESET});
        rdr(CCC_ADDR_MSR);
        check(rd[CCC_MSR_SWITCH_BIT], 1'b0);
        rdr(8'h08);
        check(err, 1'b1);
        check(rd, 32'h0);
        check(half_len, CCC_XTAL_HALF);
    endtask
    task automatic t_codes;
        for (int c = 0; c < 4; c++) begin
            wr(CCC_ADDR_CFG, 32'(c));
            cycles(40);
            check(half_len, 8'h01 << c);
        end
        wr(CCC_ADDR_CFG, 32'hC2);
        cycles(40);
        check(half_len, 8'h04);
        rdr(CCC_ADDR_CFG);
        check(rd, 32'hC2);
        wr(CCC_ADDR_CFG, 32'h03);
        cycles(40);
        clear_min;
        wr(CCC_ADDR_CFG, 32'h01);
        cycles(40);
        check(min_len, 8'h02);
    endtask
    task automatic t_switch;
        wr(CCC_ADDR_CFG, 32'h03);
        rdr(CCC_ADDR_ISTAT);
        wr(CCC_ADDR_IMASK, 32'h01);
        cycles(40);
        clear_min;
        // a long half period leaves time to see the flag before the switch lands
        clk_edge(1'b1);
        wr(CCC_ADDR_CFG, 32'h07);
        rdr(CCC_ADDR_MSR);
        check(rd[CCC_MSR_SWITCH_BIT], 1'b1);
        wait_switch;
        cycles(40);
        check(half_len, CCC_INT_HALF);
        check(min_len, CCC_INT_HALF);
        check(irq, 1'b1);
        rdr(CCC_ADDR_ISTAT);
        check(rd[CCC_IRQ_SWITCH], 1'b1);
        cycles(2);
        check(irq, 1'b0);
        for (int c = 4; c < 7; c += 2) begin
            wr(CCC_ADDR_CFG, 32'(c));
            cycles(40);
            check(half_len, CCC_INT_HALF);
        end
        wr(CCC_ADDR_IMASK, 32'h00);
        wr(CCC_ADDR_CFG, 32'h02);
        wait_switch;
        cycles(40);
        check(half_len, 8'h04);
        check(irq, 1'b0);
        rdr(CCC_ADDR_ISTAT);
        check(rd[CCC_IRQ_SWITCH], 1'b1);
    endtask
    task automatic t_stop;
        rdr(CCC_ADDR_ISTAT);
        wr(CCC_ADDR_IMASK, 32'h02);
        // request lands in a high phase, so the clock must still fall to reach level 0
        clk_edge(1'b0);
        wr(CCC_ADDR_CFG, 32'h12);
        held(1'b0);
        check(irq, 1'b1);
        wr(CCC_ADDR_CFG, 32'h32);
        held(1'b1);
        wr(CCC_ADDR_CFG, 32'h02);
        cycles(40);
        check(half_len, 8'h04);
        wr(CCC_ADDR_IMASK, 32'h00);
    endtask
    task automatic t_uart;
        int cnt;
        for (int d = 0; d < 2; d++) begin
            wr(CCC_ADDR_CSEL, 32'(d) << CCC_CSEL_DBL_BIT);
            cycles(10);
            cnt = 0;
            // window is a whole number of card clock periods of 8 cycles
            repeat (64) begin
                @(posedge pclk);
                if (uart_tick === 1'b1) cnt++;
            end
            check(cnt, 8 << d);
        end
        wr(CCC_ADDR_CSEL, 32'h00);
    endtask
    task automatic t_sync;
        logic v;
        wr(CCC_ADDR_CSEL, 32'h10);
        wr(CCC_ADDR_CFG, 32'h0A);
        cycles(4);
        check(card_clk[0], 1'b1);
        wr(CCC_ADDR_CFG, 32'h02);
        cycles(4);
        check(card_clk[0], 1'b0);
        wr(CCC_ADDR_DATA, 32'h01);
        cycles(2);
        check({io_oe, io_out}, 2'b11);
        rdr(CCC_ADDR_DATA);
        check(rd[0], 1'b1);
        wr(CCC_ADDR_DATA, 32'h00);
        cycles(20);
        check({io_oe, io_out}, 2'b10);
        rdr(CCC_ADDR_DATA);
        check(rd[0], 1'b0);
        wr(CCC_ADDR_CSEL, 32'h11);
        cycles(2);
        check(io_oe, 1'b0);
        card_drive <= 1'b1;
        card_level <= 1'b0;
        cycles(6);
        rdr(CCC_ADDR_DATA);
        check(rd[0], 1'b0);
        card_level <= 1'b1;
        cycles(6);
        rdr(CCC_ADDR_DATA);
        check(rd[0], 1'b1);
        card_drive <= 1'b0;
        wr(CCC_ADDR_CSEL, 32'h01);
        cycles(20);
        check(card_clk[0], 1'b0);
        // card 2 still holds its reset code, so its clock toggles every cycle
        v = card_clk[1];
        cycles(1);
        check(card_clk[1], !v);
        wr(CCC_ADDR_CSEL, 32'h00);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        card_drive = 1'b0;
        card_level = 1'b1;
        clr_min = 1'b0;
        num_errors = 0;
        total_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_codes;
        t_switch;
        t_stop;
        t_uart;
        t_sync;
        end_sim;
    end
    initial begin
        repeat (100000) @(posedge pclk);
        num_errors++;
        end_sim;
    end
endmodule
